// file: rtl/wdt_evt_irq.sv
// Sticky event status, write-one-to-clear, enable mask and level interrupt.
// Assumes event inputs are one-cycle pulses.
module wdt_evt_irq #(
  parameter int N = wdt_pkg::EVT_N
) (
  input  wire logic         clock,
  input  wire logic         sys_rst,
  input  wire logic [N-1:0] evt,
  input  wire logic         clrWr,
  input  wire logic         enWr,
  input  wire logic [N-1:0] wdata,
  output logic      [N-1:0] status,
  output logic      [N-1:0] enable,
  output logic              irq
);
  typedef struct packed {
    logic [N-1:0] status;
    logic [N-1:0] enable;
    logic         irq;
  } wdt_irq_state_type;

  wdt_irq_state_type st_r;
  wdt_irq_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (enWr) begin
      st_nxt.enable = wdata;
    end
    // An event in the clearing cycle survives the clear
    st_nxt.status = (st_r.status & ~(clrWr ? wdata : '0)) | evt;
    st_nxt.irq    = |(st_nxt.status & st_nxt.enable);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{status: '0, enable: N'(wdt_pkg::EVT_EN_RST), irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign enable = st_r.enable;
  assign irq    = st_r.irq;
endmodule : wdt_evt_irq

// file: rtl/wdt_osc_counter.sv
// Watchdog period counter, advanced by oscillator ticks.
// Assumes oscTick is a one-cycle pulse synchronous to clock.
module wdt_osc_counter #(
  parameter int CNT_W = wdt_pkg::CNT_W
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             oscTick,
  input  wire logic             restart,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expire
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             expire;
  } wdt_cnt_state_type;

  wdt_cnt_state_type st_r;
  wdt_cnt_state_type st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.expire = 1'b0;
    // Restart beats a coincident tick so a late restart never times out
    if (restart || !run) begin
      st_nxt.cnt = '0; // [RULE18]
    end else if (oscTick) begin // [RULE13]
      if (st_r.cnt >= limit) begin
        st_nxt.cnt    = '0;
        st_nxt.expire = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign expire = st_r.expire;
endmodule : wdt_osc_counter

// file: rtl/wdt_pkg.sv
// Shared constants and types for the watchdog timer control block.
// Assumes one system clock; the watchdog oscillator arrives as a tick pulse.
package wdt_pkg;
  localparam int          DATA_W         = 8;
  localparam int          ADDR_W         = 8;
  localparam int          CNT_W          = 20;
  localparam int          BASE_LOG2      = 11;
  localparam int          EVT_N          = 2;
  localparam int          OSC_HZ         = 128000;

  localparam logic [7:0]  CTRL_OFS       = 8'h60;
  localparam logic [7:0]  RSTAT_OFS      = 8'h64;
  localparam logic [7:0]  EVT_STAT_OFS   = 8'h68;
  localparam logic [7:0]  EVT_CLR_OFS    = 8'h6c;
  localparam logic [7:0]  EVT_EN_OFS     = 8'h70;

  localparam int          FLAG_BIT       = 7;
  localparam int          IE_BIT         = 6;
  localparam int          PS_HI_BIT      = 5;
  localparam int          CE_BIT         = 4;
  localparam int          RE_BIT         = 3;
  localparam int          PS_LO_MSB      = 2;
  localparam int          RST_FLAG_BIT   = 3;
  localparam int          EVT_TIMEOUT    = 0;
  localparam int          EVT_REFUSED    = 1;

  localparam logic [2:0]  CE_HOLD_CYCLES = 3'h4;
  localparam logic [3:0]  PS_MAX_CODE    = 4'h9;
  localparam logic [3:0]  PS_RST         = 4'h0;
  localparam logic        RE_RST         = 1'h0;
  localparam logic [1:0]  EVT_EN_RST     = 2'h0;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } wdt_bus_req_type;

  typedef enum logic [1:0] {
    WDT_STOPPED  = 2'b00,
    WDT_IRQ      = 2'b01,
    WDT_RESET    = 2'b10,
    WDT_COMBINED = 2'b11
  } wdt_mode_type;
endpackage : wdt_pkg

// file: rtl/wdt_timer_ctrl.sv
// Watchdog timer control: control/status register, timed change sequence,
// mode decode, time-out actions and the reset-cause flag.
// Assumes a single clock; oscTick, restartReq and vectorTaken are one-cycle
// pulses from the oscillator, the core and the interrupt controller.

// Operation
// [RULE1] Time-out in interrupt operation sets flag
// [RULE2] Vector taken or write-one clears flag
// [RULE3] Request irq when flag, enable, global set
// [RULE4] Interrupt-only mode interrupts every time-out
// [RULE5] Combined mode: first time-out sets flag
// [RULE6] Combined vector clears enable and flag
// [RULE7] Combined second time-out unserviced forces reset
// [RULE8] Software re-arms interrupt enable after servicing
// [RULE9] Clearing reset enable, prescaler need change-enable
// [RULE10] Change-enable self-clears after four clocks
// [RULE11] Reset-cause flag holds reset enable high
// [RULE12] Prescaler selects 2048 to 1048576 oscillator cycles
// [RULE13] Counter advances on watchdog oscillator ticks
// [RULE14] Fuse forces reset-only, interrupt enable zero
// [RULE15] Reset-only mode resets on time-out
// [RULE16] Software opens change window, writes within four
// [RULE17] Both enables clear: counter stopped, no action
// [RULE18] Restart instruction clears the counter
module wdt_timer_ctrl #(
  parameter int CNT_W = wdt_pkg::CNT_W
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire wdt_pkg::wdt_bus_req_type busReq,
  output logic [wdt_pkg::DATA_W-1:0]   rdata,
  input  wire logic                    oscTick,
  input  wire logic                    restartReq,
  input  wire logic                    vectorTaken,
  input  wire logic                    globalIrqEnable,
  input  wire logic                    alwaysOnFuse,
  output logic                         wdtIrqReq,
  output logic                         wdtSysReset,
  output logic                         irq
);
  typedef struct packed {
    logic                       flag;
    logic                       ie;
    logic                       ce;
    logic                       re;
    logic [3:0]                 ps;
    logic [2:0]                 ceCnt;
    logic                       rstFlag;
    logic [wdt_pkg::DATA_W-1:0] rdata;
    logic                       irqReq;
    logic                       sysReset;
  } wdt_ctrl_state_type;

  wdt_ctrl_state_type         st_r;
  wdt_ctrl_state_type         st_nxt;
  wdt_pkg::wdt_mode_type      mode;
  logic                       reEff;
  logic                       ieEff;
  logic                       expire;
  logic                       refused;
  logic                       ctrlWr;
  logic                       rstatWr;
  logic [3:0]                 psEff;
  logic [3:0]                 psNew;
  logic [CNT_W-1:0]           limit;
  logic [wdt_pkg::EVT_N-1:0]  evtStatus;
  logic [wdt_pkg::EVT_N-1:0]  evtEnable;
  logic [wdt_pkg::DATA_W-1:0] ctrlView;

  // Reserved prescaler codes behave as the longest period
  assign psEff = (st_r.ps > wdt_pkg::PS_MAX_CODE) ? wdt_pkg::PS_MAX_CODE : st_r.ps;
  assign limit = CNT_W'(({1'b0, CNT_W'(1)} << (wdt_pkg::BASE_LOG2 + int'(psEff)))
                 - {1'b0, CNT_W'(1)}); // [RULE12]

  assign reEff = st_r.re | st_r.rstFlag | alwaysOnFuse; // [RULE11] [RULE14]
  assign ieEff = st_r.ie & ~alwaysOnFuse; // [RULE14]

  assign ctrlWr  = busReq.wr && (busReq.addr == wdt_pkg::CTRL_OFS);
  assign rstatWr = busReq.wr && (busReq.addr == wdt_pkg::RSTAT_OFS);
  assign psNew   = {busReq.wdata[wdt_pkg::PS_HI_BIT],
                    busReq.wdata[wdt_pkg::PS_LO_MSB:0]};

  assign ctrlView = {st_r.flag, ieEff, st_r.ps[3], st_r.ce, reEff, st_r.ps[2:0]};

  always_comb begin
    case ({reEff, ieEff})
      2'b01:   mode = wdt_pkg::WDT_IRQ; // [RULE4]
      2'b10:   mode = wdt_pkg::WDT_RESET; // [RULE15]
      2'b11:   mode = wdt_pkg::WDT_COMBINED;
      default: mode = wdt_pkg::WDT_STOPPED;
    endcase
  end

  wdt_osc_counter #(
    .CNT_W   (CNT_W)
  ) u_counter (
    .clock   (clock),
    .sys_rst (sys_rst),
    .oscTick (oscTick),
    .restart (restartReq | st_r.sysReset), // [RULE18]
    .run     (mode != wdt_pkg::WDT_STOPPED), // [RULE17]
    .limit   (limit),
    .expire  (expire)
  );

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sysReset = 1'b0;
    refused         = 1'b0;

    // Change window countdown
    if (st_r.ceCnt != 3'h0) begin
      st_nxt.ceCnt = st_r.ceCnt - 3'h1;
      if (st_r.ceCnt == 3'h1) begin
        st_nxt.ce = 1'b0; // [RULE10]
      end
    end

    // Hardware clears on vector entry; combined mode drops to reset-only
    if (vectorTaken) begin
      st_nxt.flag = 1'b0; // [RULE2]
      if (mode == wdt_pkg::WDT_COMBINED) begin
        st_nxt.ie = 1'b0; // [RULE6]
      end
    end

    if (ctrlWr) begin
      if (busReq.wdata[wdt_pkg::FLAG_BIT]) begin
        st_nxt.flag = 1'b0; // [RULE2]
      end
      st_nxt.ie = busReq.wdata[wdt_pkg::IE_BIT] & ~alwaysOnFuse; // [RULE14]
      if (busReq.wdata[wdt_pkg::RE_BIT]) begin
        st_nxt.re = 1'b1;
      end else if (st_r.ce && !st_r.rstFlag && !alwaysOnFuse) begin
        st_nxt.re = 1'b0; // [RULE9] [RULE11] [RULE16]
      end else if (reEff) begin
        refused = 1'b1;
      end
      if (st_r.ce) begin
        st_nxt.ps = psNew; // [RULE9]
      end else if (psNew != st_r.ps) begin
        refused = 1'b1;
      end
      if (busReq.wdata[wdt_pkg::CE_BIT]) begin
        st_nxt.ce    = 1'b1;
        st_nxt.ceCnt = wdt_pkg::CE_HOLD_CYCLES; // [RULE10]
      end else begin
        // A write without change-enable consumes the open window
        st_nxt.ce    = 1'b0;
        st_nxt.ceCnt = 3'h0;
      end
    end

    // Time-out actions; a set here wins over any clear above
    if (expire) begin
      case (mode)
        wdt_pkg::WDT_IRQ: begin
          st_nxt.flag = 1'b1; // [RULE1] [RULE4]
        end
        wdt_pkg::WDT_RESET: begin
          st_nxt.sysReset = 1'b1; // [RULE15] [RULE14]
        end
        wdt_pkg::WDT_COMBINED: begin
          if (st_r.flag) begin
            st_nxt.sysReset = 1'b1; // [RULE7]
          end else begin
            st_nxt.flag = 1'b1; // [RULE5] [RULE1]
          end
        end
        default: begin
          st_nxt.sysReset = 1'b0; // [RULE17]
        end
      endcase
    end

    if (rstatWr && !busReq.wdata[wdt_pkg::RST_FLAG_BIT]) begin
      st_nxt.rstFlag = 1'b0;
    end
    if (st_nxt.sysReset) begin
      st_nxt.rstFlag = 1'b1;
    end
    // Reset enable is held set while the cause flag is set
    if (st_r.rstFlag) begin
      st_nxt.re = 1'b1; // [RULE11]
    end

    // Software must re-arm ie after each interrupt to stay combined
    st_nxt.irqReq = st_nxt.flag & st_nxt.ie & ~alwaysOnFuse
                    & globalIrqEnable; // [RULE3] [RULE8]

    st_nxt.rdata = '0;
    if (busReq.rd) begin
      case (busReq.addr)
        wdt_pkg::CTRL_OFS:     st_nxt.rdata = ctrlView;
        wdt_pkg::RSTAT_OFS:    st_nxt.rdata = 8'(st_r.rstFlag) << wdt_pkg::RST_FLAG_BIT;
        wdt_pkg::EVT_STAT_OFS: st_nxt.rdata = 8'(evtStatus);
        wdt_pkg::EVT_EN_OFS:   st_nxt.rdata = 8'(evtEnable);
        default:               st_nxt.rdata = 8'h00;
      endcase
    end
  end

  wdt_evt_irq #(
    .N       (wdt_pkg::EVT_N)
  ) u_events (
    .clock   (clock),
    .sys_rst (sys_rst),
    .evt     ({refused, expire}),
    .clrWr   (busReq.wr && (busReq.addr == wdt_pkg::EVT_CLR_OFS)),
    .enWr    (busReq.wr && (busReq.addr == wdt_pkg::EVT_EN_OFS)),
    .wdata   (busReq.wdata[wdt_pkg::EVT_N-1:0]),
    .status  (evtStatus),
    .enable  (evtEnable),
    .irq     (irq)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '{flag: 1'b0, ie: 1'b0, ce: 1'b0, re: wdt_pkg::RE_RST,
                ps: wdt_pkg::PS_RST, ceCnt: 3'h0, rstFlag: 1'b0,
                rdata: 8'h00, irqReq: 1'b0, sysReset: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata       = st_r.rdata;
  assign wdtIrqReq   = st_r.irqReq;
  assign wdtSysReset = st_r.sysReset;
endmodule : wdt_timer_ctrl

// file: verification/wdt_timer_ctrl_chk.sv
// Port-level assertions for the watchdog timer control block.
// Assumes one clock domain and a bind from the bench top.
module wdt_timer_ctrl_chk #(
  parameter int CNT_W = wdt_pkg::CNT_W
) (
  input wire logic                       clock,
  input wire logic                       sys_rst,
  input wire wdt_pkg::wdt_bus_req_type   busReq,
  input wire logic [wdt_pkg::DATA_W-1:0] rdata,
  input wire logic                       oscTick,
  input wire logic                       restartReq,
  input wire logic                       vectorTaken,
  input wire logic                       globalIrqEnable,
  input wire logic                       alwaysOnFuse,
  input wire logic                       wdtIrqReq,
  input wire logic                       wdtSysReset,
  input wire logic                       irq
);
  localparam int  MIN_TICKS = 2047;
  logic [CNT_W:0] ticks_r;
  logic           ctrlWr;
  assign ctrlWr = busReq.wr && busReq.addr == wdt_pkg::CTRL_OFS;
  // Saturates, so a long stop cannot wrap into a false short period
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) ticks_r <= '0;
    else if (restartReq || wdtSysReset) ticks_r <= '0;
    else if (oscTick && !ticks_r[CNT_W]) ticks_r <= ticks_r + 1'b1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence ctrlRd; busReq.rd && busReq.addr == wdt_pkg::CTRL_OFS; endsequence
  sequence winOpen; ctrlWr && busReq.wdata[wdt_pkg::CE_BIT]; endsequence
  AST_CE_OPEN: assert property (
    winOpen ##1 (!busReq.wr)[*2] ##0 ctrlRd |=> rdata[wdt_pkg::CE_BIT])
    else $error("change enable closed early");
  AST_CE_SHUT: assert property (
    winOpen ##1 (!busReq.wr)[*5] ##0 ctrlRd |=> !rdata[wdt_pkg::CE_BIT])
    else $error("change enable still open");
  AST_IRQ_GLOBAL: assert property (
    wdtIrqReq |-> $past(globalIrqEnable) && !$past(alwaysOnFuse))
    else $error("irq without global enable");
  AST_IRQ_HOLD: assert property (
    wdtIrqReq && globalIrqEnable && !alwaysOnFuse && !vectorTaken && !ctrlWr |=> wdtIrqReq)
    else $error("flag dropped by itself");
  AST_VEC_CLR: assert property (
    vectorTaken |=> !wdtIrqReq)
    else $error("vector left irq pending");
  AST_RST_GAP: assert property (
    wdtSysReset |=> !wdtSysReset [*8])
    else $error("reset pulse too long");
  AST_RESTART: assert property (
    restartReq |-> ##2 !wdtSysReset [*8])
    else $error("reset soon after restart");
  AST_MIN_PERIOD: assert property (
    wdtSysReset |-> ticks_r >= MIN_TICKS)
    else $error("time-out too short");
endmodule : wdt_timer_ctrl_chk

// file: verification/wdt_timer_ctrl_tb_top.sv
// Self-checking bench for the watchdog timer control block.
// Assumes the bench alone drives the block; an oscillator tick every clock.
module wdt_timer_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
  $display("wrong value %s exp %0h got %0h", n, e, s); end end
  logic                     clock = 1'b0;
  logic                     sys_rst = 1'b1;
  wdt_pkg::wdt_bus_req_type busReq = '0;
  logic                     oscTick = 1'b0;
  logic                     restartReq = 1'b0;
  logic                     vectorTaken = 1'b0;
  logic                     globalIrqEnable = 1'b0;
  logic                     alwaysOnFuse = 1'b0;
  logic [7:0]               rdata;
  logic [7:0]               v;
  logic [1:0]               q;
  logic                     wdtIrqReq;
  logic                     wdtSysReset;
  logic                     irq;
  int                       n_errors = 0;
  int                       samples_checked = 0;
  int                       cyc = 0;
  int                       nRst = 0;
  int                       mc = 0;
  int                       win = 0;
  int                       rf = 0;
  int                       n;
  int                       per[$] = '{2048, 4096, 8192};
  wdt_timer_ctrl u_dut (
    .clock(clock), .sys_rst(sys_rst), .busReq(busReq), .rdata(rdata), .oscTick(oscTick),
    .restartReq(restartReq), .vectorTaken(vectorTaken), .globalIrqEnable(globalIrqEnable),
    .alwaysOnFuse(alwaysOnFuse), .wdtIrqReq(wdtIrqReq), .wdtSysReset(wdtSysReset), .irq(irq));
  always #50 clock = ~clock;
  always @(posedge clock) begin
    cyc++;
    if (wdtSysReset === 1'b1) begin
      nRst++;
      rf = 1;
    end
    if (cyc == 50000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // Control view expected after a write; the window matters for reset-enable clears and prescaler changes
  function automatic int mdl(int c, int d, int o, int f);
    int r;
    r = (c & ~d & 8'h80) | (d & 8'h40) | ((o != 0 ? d : c) & 8'h27);
    if (d[3] || f != 0 || (c[3] && o == 0)) r = r | 8'h08;
    return r;
  endfunction : mdl
  task automatic bus(input logic [7:0] a, d, input logic w, r);
    busReq <= '{addr: a, wdata: d, wr: w, rd: r};
    @(posedge clock);
  endtask : bus
  task automatic wr(input logic [7:0] a, d);
    bus(a, d, 1'b1, 1'b0);
    bus(8'h00, 8'h00, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    win = 0;
    bus(a, 8'h00, 1'b0, 1'b1);
    busReq <= '0;
    @(negedge clock);
    v = rdata;
    @(posedge clock);
  endtask : rd
  task automatic wc(input int d);
    wr(wdt_pkg::CTRL_OFS, d[7:0]);
    mc = mdl(mc, d, win, rf);
    win = d[4];
  endtask : wc
  task automatic chkc();
    rd(wdt_pkg::CTRL_OFS);
    `CHK("ctrl", mc & 8'hef, v & 8'hef)
  endtask : chkc
  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask : step
  task automatic kick(input bit vec);
    if (vec) vectorTaken <= 1'b1;
    else restartReq <= 1'b1;
    @(posedge clock);
    vectorTaken <= 1'b0;
    restartReq <= 1'b0;
  endtask : kick
  task automatic waitEv(input bit rs);
    n = 0;
    while ((rs ? wdtSysReset : wdtIrqReq) !== 1'b1 && n < 9000) begin
      @(negedge clock);
      n++;
    end
    q = {wdtIrqReq, wdtSysReset};
    @(posedge clock);
  endtask : waitEv
  initial begin
    void'($urandom(79));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    oscTick <= 1'b1;
    @(posedge clock);
    chkc();
    rd(8'($urandom_range(95, 0)));
    `CHK("unmapped", 0, v)
    step(2100);
    `CHK("stopped", 0, nRst)
    rd(wdt_pkg::EVT_STAT_OFS);
    `CHK("stopped evt", 0, v)
    $display("test stopped done");
    wc(8'h40);
    kick(1'b0);
    step(2060);
    mc = mc | 8'h80;
    chkc();
    `CHK("irq no global", 0, wdtIrqReq)
    globalIrqEnable <= 1'b1;
    step(2);
    `CHK("irq global", 1, wdtIrqReq)
    kick(1'b1);
    step(1);
    `CHK("irq after vector", 0, wdtIrqReq)
    mc = mc & 8'h7f;
    chkc();
    kick(1'b0);
    waitEv(1'b0);
    `CHK("irq period", 1, n >= 2048 && n <= 2051)
    `CHK("irq no reset", 0, q[0])
    mc = mc | 8'h80;
    wc(8'hc0);
    chkc();
    rd(wdt_pkg::EVT_STAT_OFS);
    `CHK("evt timeout", 1, v[0])
    `CHK("evt masked", 0, irq)
    wr(wdt_pkg::EVT_EN_OFS, 8'h01);
    step(1);
    `CHK("evt irq", 1, irq)
    wr(wdt_pkg::EVT_CLR_OFS, 8'h01);
    step(1);
    `CHK("evt cleared", 0, irq)
    wc(8'h00);
    $display("test interrupt done");
    foreach (per[i]) begin
      wc((mc & 8'h6f) | 8'h18);
      wc(8'h08 | i);
      kick(1'b0);
      waitEv(1'b1);
      `CHK("period", 1, n >= per[i] && n <= per[i] + 3)
      `CHK("reset no irq", 0, q[1])
      chkc();
    end
    wc((mc & 8'h6f) | 8'h18);
    wc(8'h2c);
    chkc();
    wc(8'h00);
    chkc();
    rd(wdt_pkg::EVT_STAT_OFS);
    `CHK("refused evt", 1, v[1])
    wc((mc & 8'h6f) | 8'h18);
    wc(8'h00);
    chkc();
    rd(wdt_pkg::RSTAT_OFS);
    `CHK("reset flag", 8'h08, v)
    wr(wdt_pkg::RSTAT_OFS, 8'h00);
    rf = 0;
    wc((mc & 8'h6f) | 8'h18);
    wc(8'h00);
    chkc();
    wc(8'h10);
    rd(wdt_pkg::CTRL_OFS);
    `CHK("ce open", 1, v[4])
    bus(8'h00, 8'h00, 1'b0, 1'b0);
    rd(wdt_pkg::CTRL_OFS);
    `CHK("ce shut", 0, v[4])
    $display("test change sequence done");
    wc(8'h48);
    kick(1'b0);
    waitEv(1'b0);
    `CHK("first no reset", 0, q[0])
    mc = mc | 8'h80;
    chkc();
    waitEv(1'b1);
    `CHK("second resets", 1, q[0])
    wc(8'hc8);
    kick(1'b0);
    waitEv(1'b0);
    kick(1'b1);
    mc = mc & 8'h3f;
    chkc();
    wc(8'h48);
    chkc();
    kick(1'b0);
    waitEv(1'b0);
    `CHK("rearmed no reset", 0, q[0])
    kick(1'b1);
    $display("test combined done");
    n = nRst;
    repeat (4) begin
      step(1500);
      kick(1'b0);
    end
    `CHK("restart holds", n, nRst)
    waitEv(1'b1);
    `CHK("reset period", 1, n >= 2048 && n <= 2051)
    $display("test restart done");
    alwaysOnFuse <= 1'b1;
    wc(8'h40);
    rd(wdt_pkg::CTRL_OFS);
    `CHK("fuse ctrl", 8'h08, v & 8'hef)
    kick(1'b0);
    waitEv(1'b1);
    `CHK("fuse period", 1, n >= 2048 && n <= 2051)
    `CHK("fuse no irq", 0, q[1])
    $display("test fuse done");
    conclude();
  end
endmodule : wdt_timer_ctrl_tb_top
bind wdt_timer_ctrl wdt_timer_ctrl_chk #(.CNT_W(CNT_W)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .busReq(busReq), .rdata(rdata), .oscTick(oscTick),
  .restartReq(restartReq), .vectorTaken(vectorTaken), .globalIrqEnable(globalIrqEnable),
  .alwaysOnFuse(alwaysOnFuse), .wdtIrqReq(wdtIrqReq), .wdtSysReset(wdtSysReset), .irq(irq));
